// ---- hme_params.svh ----
// constants for the halt / machine-check / internal register block
// assumes a word-addressed wishbone slave, index times four = byte address
`ifndef HME_PARAMS_SVH
`define HME_PARAMS_SVH
`define HME_IX_RX_STAT 6'h1C
`define HME_IX_RX_DATA 6'h1D
`define HME_IX_TX_STAT 6'h1E
`define HME_IX_TX_DATA 6'h1F
`define HME_IX_TB_DIS 6'h24
`define HME_IX_CACHE_DIS 6'h25
`define HME_IX_MC_SUMMARY 6'h26
`define HME_IX_CACHE_ERR 6'h27
`define HME_IX_ACCEL 6'h28
`define HME_IX_BP_FAULT 6'h30
`define HME_IX_BP_SILO 6'h31
`define HME_IX_BP_SILO_CMP 6'h32
`define HME_IX_BP_MAINT 6'h33
`define HME_IX_BP_ERR 6'h34
`define HME_IX_BP_TMO 6'h35
`define HME_IX_BP_QCLR 6'h36
`define HME_IX_IO_RESET 6'h37
`define HME_IX_PERF_EN 6'h3D
`define HME_IX_SYS_ID 6'h3E
`define HME_IX_TB_CHECK 6'h3F
`define HME_IX_IRQ_STAT 6'h08
`define HME_IX_IRQ_MASK 6'h09
`define HME_IX_HALT_CODE 6'h0A
`define HME_MC_BYTE_COUNT 32'h0000000C
`define HME_MC_WORDS 3'h6
`define HME_VEC_RX 8'hF0
`define HME_VEC_TX 8'hF4
`define HME_VEC_LEVEL 5'h14
`define HME_HALT_BREAK 8'h02
`define HME_HALT_POWERUP 8'h03
`define HME_HALT_ISTK 8'h04
`define HME_HALT_DBL_MC 8'h05
`define HME_HALT_INSTR 8'h06
`define HME_HALT_VEC_B1 8'h07
`define HME_HALT_CHM_ISTK 8'h0A
`define HME_HALT_CHM_VEC 8'h0B
`define HME_HALT_VEC_MEM 8'h0C
`define HME_SID_TYPE_LSB 24
`define HME_SID_UREV_LSB 8
`define HME_TB_MISS 32'h00000001
`endif

// ---- hme_pkg.sv ----
// types for the halt / machine-check block
// assumes hme_params.svh for the numbers
package hme_pkg;
  typedef struct packed {
    logic break_seq;
    logic istk_invalid;
    logic halt_instr;
    logic kernel_mode;
    logic vec_fetch;
    logic [31:0] vector;
    logic vec_mem_err;
    logic chm;
    logic on_istk;
    logic mc_req;
  } hme_events_s;
  typedef struct packed {
    logic [7:0] mc_type;
    logic [31:0] param1;
    logic [31:0] param2;
    logic [31:0] pc;
    logic [31:0] processor_status_longword;
  } hme_mc_frame_s;
  typedef enum logic [2:0] {
    HME_RUN = 3'b001,
    HME_PUSH = 3'b010,
    HME_HALTED = 3'b100
  } hme_state_e;
endpackage

// ---- hme_core.sv ----
// halt, machine-check frame and internal register block
// assumes processor event pulses on i_sys_clk and a classic wishbone master
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "hme_params.svh"
module hme_core
  import hme_pkg::*;
#(
  parameter logic [7:0] P_CPU_TYPE = 8'hA5, // arbitrary value
  parameter logic [7:0] P_UCODE_REV = 8'h01
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire hme_events_s i_evt,
  input wire hme_mc_frame_s i_mc_frame,
  input wire logic i_rx_done,
  input wire logic i_tx_done,
  input wire logic i_console_restart,
  input wire logic i_stack_ready,
  output logic o_stack_push,
  output logic [31:0] o_stack_word,
  output logic o_halt,
  output logic [7:0] o_halt_code,
  output logic o_rsvd_operand,
  output logic o_io_reset,
  output logic o_dev_irq,
  output logic [7:0] o_dev_vector,
  output logic [4:0] o_dev_level,
  output logic o_irq
);
  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic req;
  logic wr;
  logic rd;
  logic [5:0] ix;
  logic ack_q;
  assign req = i_wb_cyc && i_wb_stb && !ack_q;
  assign wr = req && i_wb_we;
  assign rd = req && !i_wb_we;
  assign ix = i_wb_adr[7:2];

  function automatic logic is_zero_reg(input logic [5:0] a);
    is_zero_reg = (a == `HME_IX_TB_DIS) || (a == `HME_IX_CACHE_DIS) ||
      (a == `HME_IX_CACHE_ERR) || (a == `HME_IX_BP_FAULT) ||
      (a == `HME_IX_BP_SILO_CMP) || (a == `HME_IX_BP_MAINT) ||
      (a == `HME_IX_BP_ERR) || (a == `HME_IX_MC_SUMMARY) ||
      (a == `HME_IX_BP_SILO) || (a == `HME_IX_BP_TMO);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    merge = r;
  endfunction

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end
  assign o_wb_ack = ack_q;

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  logic [31:0] accel_q;
  logic [31:0] perf_q;
  logic [31:0] tx_data_q;
  logic [31:0] rx_data_q;
  logic [1:0] dev_en_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  logic [3:0] irq_evt;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      accel_q <= 32'h00000000;
      perf_q <= 32'h00000000;
      tx_data_q <= 32'h00000000;
      dev_en_q <= 2'h0;
      irq_mask_q <= 4'h0;
    end else if (wr) begin
      unique case (ix)
        `HME_IX_ACCEL: accel_q <= merge(accel_q, i_wb_dat, i_wb_sel);
        `HME_IX_PERF_EN: perf_q <= merge(perf_q, i_wb_dat, i_wb_sel);
        `HME_IX_TX_DATA: tx_data_q <= merge(tx_data_q, i_wb_dat, i_wb_sel);
        `HME_IX_RX_STAT: dev_en_q[0] <= i_wb_dat[6];
        `HME_IX_TX_STAT: dev_en_q[1] <= i_wb_dat[6];
        `HME_IX_IRQ_MASK: irq_mask_q <= i_wb_dat[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_data_q <= 32'h00000000;
    end else if (i_rx_done) begin
      rx_data_q <= tx_data_q;
    end
  end

  // io reset register: write pulses a one-cycle reset
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_io_reset <= 1'b0;
    end else begin
      o_io_reset <= wr && (ix == `HME_IX_IO_RESET);
    end
  end

  // ------------------------------------------------------------
  // reserved operand faults
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rsvd_operand <= 1'b0;
    end else begin
      o_rsvd_operand <=
        (wr && (ix == `HME_IX_BP_SILO || ix == `HME_IX_BP_TMO)) ||
        (rd && ix == `HME_IX_BP_QCLR);
    end
  end

  // ------------------------------------------------------------
  // machine check and halt
  // ------------------------------------------------------------
  hme_state_e state_q;
  logic mc_busy_q;
  logic [2:0] word_q;
  hme_mc_frame_s frame_q;
  logic [7:0] halt_d;
  logic halt_now;
  logic mc_clear;
  assign mc_clear = wr && (ix == `HME_IX_MC_SUMMARY);

  // priority: hard vector error, vector bit 1, stack, double machine check, then chm, halt instr and break
  always_comb begin
    halt_d = 8'h00;
    if (i_evt.vec_fetch && i_evt.vec_mem_err) begin
      halt_d = `HME_HALT_VEC_MEM;
    end else if (i_evt.vec_fetch && i_evt.vector[1]) begin
      halt_d = `HME_HALT_VEC_B1;
    end else if (i_evt.vec_fetch && i_evt.istk_invalid) begin
      halt_d = `HME_HALT_ISTK;
    end else if (i_evt.mc_req && mc_busy_q) begin
      halt_d = `HME_HALT_DBL_MC;
    end else if (i_evt.chm && i_evt.on_istk) begin
      halt_d = `HME_HALT_CHM_ISTK;
    end else if (i_evt.chm && i_evt.vec_fetch && i_evt.vector[0]) begin
      halt_d = `HME_HALT_CHM_VEC;
    end else if (i_evt.halt_instr && i_evt.kernel_mode) begin
      halt_d = `HME_HALT_INSTR;
    end else if (i_evt.break_seq) begin
      halt_d = `HME_HALT_BREAK;
    end
  end
  assign halt_now = (halt_d != 8'h00) && (state_q != HME_HALTED);

  // set wins over the summary-register clear
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mc_busy_q <= 1'b0;
    end else if (i_evt.mc_req && state_q == HME_RUN && !halt_now) begin
      mc_busy_q <= 1'b1;
    end else if (mc_clear) begin
      mc_busy_q <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= HME_RUN;
      word_q <= 3'h0;
      frame_q <= '0;
      o_halt_code <= 8'h00;
    end else begin
      unique case (state_q)
        HME_RUN: begin
          if (halt_now) begin
            state_q <= HME_HALTED;
            o_halt_code <= halt_d;
          end else if (i_evt.mc_req) begin
            state_q <= HME_PUSH;
            word_q <= 3'h0;
            frame_q <= i_mc_frame;
          end
        end
        HME_PUSH: begin
          if (halt_now) begin
            state_q <= HME_HALTED;
            o_halt_code <= halt_d;
          end else if (i_stack_ready) begin
            if (word_q == `HME_MC_WORDS - 3'h1) begin
              state_q <= HME_RUN;
            end
            word_q <= word_q + 3'h1;
          end
        end
        HME_HALTED: begin
          // console restart code never enters the halt register
          if (i_console_restart) begin
            state_q <= HME_RUN;
          end
        end
        default: state_q <= HME_HALTED;
      endcase
    end
  end
  assign o_halt = (state_q == HME_HALTED);

  // frame order from top of stack
  always_comb begin
    o_stack_push = (state_q == HME_PUSH);
    unique case (word_q)
      3'h0: o_stack_word = `HME_MC_BYTE_COUNT;
      3'h1: o_stack_word = {24'h000000, frame_q.mc_type};
      3'h2: o_stack_word = frame_q.param1;
      3'h3: o_stack_word = frame_q.param2;
      3'h4: o_stack_word = frame_q.pc;
      default: o_stack_word = frame_q.processor_status_longword;
    endcase
  end

  // ------------------------------------------------------------
  // storage device vectors and interrupts
  // ------------------------------------------------------------
  // bit0 rx done, bit1 tx done, bit2 halt, bit3 reserved operand
  assign irq_evt = {o_rsvd_operand, halt_now, i_tx_done, i_rx_done};

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_stat_q <= 4'h0;
    end else begin
      irq_stat_q <= irq_evt |
        (irq_stat_q & ~((wr && ix == `HME_IX_IRQ_STAT) ? i_wb_dat[3:0] : 4'h0));
    end
  end
  assign o_irq = |(irq_stat_q & irq_mask_q);

  // rx wins when both pending: it frees the device for the next block
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_dev_irq <= 1'b0;
      o_dev_vector <= 8'h00;
      o_dev_level <= 5'h00;
    end else begin
      o_dev_irq <= (irq_stat_q[0] && dev_en_q[0]) ||
                   (irq_stat_q[1] && dev_en_q[1]);
      o_dev_level <= `HME_VEC_LEVEL;
      o_dev_vector <= (irq_stat_q[0] && dev_en_q[0]) ? `HME_VEC_RX
                                                     : `HME_VEC_TX;
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wb_dat <= 32'h00000000;
    end else if (rd) begin
      if (is_zero_reg(ix)) begin
        o_wb_dat <= 32'h00000000;
      end else begin
        unique case (ix)
          `HME_IX_RX_STAT: o_wb_dat <= {24'h0, irq_stat_q[0], dev_en_q[0],
                                        6'h00};
          `HME_IX_RX_DATA: o_wb_dat <= rx_data_q;
          `HME_IX_TX_STAT: o_wb_dat <= {24'h0, irq_stat_q[1], dev_en_q[1],
                                        6'h00};
          `HME_IX_ACCEL: o_wb_dat <= accel_q;
          `HME_IX_PERF_EN: o_wb_dat <= perf_q;
          `HME_IX_SYS_ID: o_wb_dat <= {P_CPU_TYPE, 8'h00, P_UCODE_REV,
                                       8'h00};
          `HME_IX_TB_CHECK: o_wb_dat <= `HME_TB_MISS;
          `HME_IX_IRQ_STAT: o_wb_dat <= {28'h0, irq_stat_q};
          `HME_IX_IRQ_MASK: o_wb_dat <= {28'h0, irq_mask_q};
          `HME_IX_HALT_CODE: o_wb_dat <= {24'h0, o_halt_code};
          default: o_wb_dat <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- hme_core_sva.sv ----
// checker for the halt, machine-check and register block ports
// assumes one clock and a bind into every hme_core instance
`timescale 1ns/1ps
`default_nettype none
`include "hme_params.svh"
module hme_core_sva
  import hme_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic o_wb_ack,
  input wire hme_events_s i_evt,
  input wire logic i_console_restart,
  input wire logic o_stack_push,
  input wire logic [31:0] o_stack_word,
  input wire logic o_halt,
  input wire logic [7:0] o_halt_code,
  input wire logic o_rsvd_operand,
  input wire logic o_dev_irq,
  input wire logic [7:0] o_dev_vector,
  input wire logic [4:0] o_dev_level
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  logic take;
  logic quiet;
  assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
  // lone events only, so halt priority cannot mask them
  assign quiet = !o_halt && !i_evt.vec_fetch && !i_evt.chm && !i_evt.mc_req
    && !i_evt.istk_invalid;
  property p_ack; take |=> o_wb_ack ##1 !o_wb_ack; endproperty
  a_ack: assert property (p_ack)
    else $error("bus acknowledge is not a single pulse");
  property p_brk;
    quiet && i_evt.break_seq && !i_evt.halt_instr
      |=> o_halt && o_halt_code == `HME_HALT_BREAK;
  endproperty
  a_brk: assert property (p_brk)
    else $error("break sequence did not halt with its code");
  property p_hlt;
    quiet && i_evt.halt_instr && i_evt.kernel_mode
      |=> o_halt && o_halt_code == `HME_HALT_INSTR;
  endproperty
  a_hlt: assert property (p_hlt)
    else $error("kernel halt instruction code wrong");
  property p_no3; o_halt |-> o_halt_code != `HME_HALT_POWERUP; endproperty
  a_no3: assert property (p_no3)
    else $error("power-up code reported as a halt");
  property p_silo;
    take && i_wb_we && i_wb_adr[7:2] inside {`HME_IX_BP_SILO, `HME_IX_BP_TMO}
      |=> o_rsvd_operand;
  endproperty
  a_silo: assert property (p_silo)
    else $error("silo or timeout write gave no operand fault");
  property p_qclr;
    take && !i_wb_we && i_wb_adr[7:2] == `HME_IX_BP_QCLR |=> o_rsvd_operand;
  endproperty
  a_qclr: assert property (p_qclr)
    else $error("quadword clear read gave no operand fault");
  property p_frame;
    $rose(o_stack_push) |-> o_stack_word == `HME_MC_BYTE_COUNT;
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame does not open with the byte count");
  property p_vec;
    o_dev_irq |-> o_dev_level == `HME_VEC_LEVEL
      && o_dev_vector inside {`HME_VEC_RX, `HME_VEC_TX};
  endproperty
  a_vec: assert property (p_vec)
    else $error("storage interrupt vector or level wrong");
  property p_hold;
    o_halt && !i_console_restart |=> o_halt && $stable(o_halt_code);
  endproperty
  a_hold: assert property (p_hold)
    else $error("halt code changed before restart");
  c_halt: cover property ($rose(o_halt));
  c_push: cover property (o_stack_push [*6]);
  c_irq: cover property ($rose(o_dev_irq));
endmodule
bind hme_core hme_core_sva hme_core_sva_inst (
  .i_sys_clk, .i_arst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
  .o_wb_ack, .i_evt, .i_console_restart, .o_stack_push, .o_stack_word,
  .o_halt, .o_halt_code, .o_rsvd_operand, .o_dev_irq, .o_dev_vector,
  .o_dev_level
);
`default_nettype wire

// ---- hme_console_model.sv ----
// console and storage device seen from the processor block
// assumes requests from the bench, one clock, async low reset
`timescale 1ns/1ps
`default_nettype none
module hme_console_model (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_stall,
  input wire logic i_rx_req,
  input wire logic i_tx_req,
  input wire logic i_restart_req,
  output logic o_rx_done,
  output logic o_tx_done,
  output logic o_restart,
  output logic o_stack_ready
);
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rx_done <= 1'h0;
      o_tx_done <= 1'h0;
      o_restart <= 1'h0;
      o_stack_ready <= 1'h0;
    end else begin
      o_rx_done <= i_rx_req;
      o_tx_done <= i_tx_req;
      // only a plain restart leaves a halt; power-up code never sent
      o_restart <= i_restart_req;
      // slow stack accepts every other cycle to stretch the frame push
      o_stack_ready <= i_stall ? !o_stack_ready : 1'h1;
    end
  end
endmodule
`default_nettype wire

// ---- hme_core_tb.sv ----
// self-checking bench for the halt and machine-check block
// assumes the console model answers done, restart and stack ready
`timescale 1ns/1ps
`default_nettype none
`include "hme_params.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module hme_core_tb
  import hme_pkg::*;
;
  localparam logic [7:0] CPU_T = 8'h5C; // arbitrary value
  localparam logic [7:0] UREV = 8'h07;
  logic i_sys_clk = 1'h0, i_arst_n = 1'h0, i_wb_cyc = 1'h0, i_wb_stb = 1'h0;
  logic i_wb_we = 1'h0, stall = 1'h0, rx_req = 1'h0, tx_req = 1'h0;
  logic rs_req = 1'h0, irq_a, o_wb_ack, o_stack_push, o_halt, o_dev_irq;
  logic i_rx_done, i_tx_done, i_console_restart, i_stack_ready, o_irq;
  logic o_rsvd_operand, o_io_reset;
  logic [7:0] i_wb_adr = 8'h00, o_halt_code, o_dev_vector;
  logic [3:0] i_wb_sel = 4'hF;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat, o_stack_word, rd;
  logic [4:0] o_dev_level;
  hme_events_s i_evt = '0;
  hme_mc_frame_s i_mc_frame = '0;
  logic [31:0] words [$];
  int n_fail = 0, total_checks = 0, n_rsvd = 0, n_iorst = 0;
  // index, write first, expected, mask
  logic [70:0] rows [15] = '{{6'h24, 1'h1, 32'h0, 32'hFFFFFFFF},
    {6'h25, 1'h1, 32'h0, 32'hFFFFFFFF}, {6'h26, 1'h0, 32'h0, 32'hFFFFFFFF},
    {6'h27, 1'h1, 32'h0, 32'hFFFFFFFF}, {6'h30, 1'h1, 32'h0, 32'hFFFFFFFF},
    {6'h31, 1'h0, 32'h0, 32'hFFFFFFFF}, {6'h32, 1'h1, 32'h0, 32'hFFFFFFFF},
    {6'h33, 1'h1, 32'h0, 32'hFFFFFFFF}, {6'h34, 1'h1, 32'h0, 32'hFFFFFFFF},
    {6'h35, 1'h0, 32'h0, 32'hFFFFFFFF}, {6'h3A, 1'h1, 32'h0, 32'hFFFFFFFF},
    {6'h3F, 1'h0, `HME_TB_MISS, 32'hFFFFFFFF},
    {6'h3E, 1'h1, CPU_T, 8'h00, UREV, 8'h00, 32'hFF00FF00},
    {6'h28, 1'h1, 32'hFFFFFFFF, 32'hFFFFFFFF},
    {6'h3D, 1'h1, 32'hFFFFFFFF, 32'hFFFFFFFF}};
  // event vector, expected halt code (00: no halt)
  logic [48:0] hrows [9] = '{{5'h10, 32'h0, 4'h0, 8'h02},
    {5'h06, 32'h0, 4'h0, 8'h06}, {5'h04, 32'h0, 4'h0, 8'h00},
    {5'h01, 32'h2, 4'h0, 8'h07}, {5'h09, 32'h0, 4'h0, 8'h04},
    {5'h00, 32'h0, 4'h6, 8'h0A}, {5'h01, 32'h1, 4'h4, 8'h0B},
    {5'h01, 32'h0, 4'h8, 8'h0C}, {5'h11, 32'h2, 4'h8, 8'h0C}};
  logic [31:0] expw [6] = '{`HME_MC_BYTE_COUNT, 32'h81, 32'h11111111,
    32'h22222222, 32'h33333333, 32'h44444444};
  hme_core #(.P_CPU_TYPE(CPU_T), .P_UCODE_REV(UREV)) hme_core_inst (
    .i_sys_clk, .i_arst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
    .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_evt, .i_mc_frame,
    .i_rx_done, .i_tx_done, .i_console_restart, .i_stack_ready,
    .o_stack_push, .o_stack_word, .o_halt, .o_halt_code, .o_rsvd_operand,
    .o_io_reset, .o_dev_irq, .o_dev_vector, .o_dev_level, .o_irq);
  hme_console_model hme_console_model_inst (.i_sys_clk, .i_arst_n,
    .i_stall(stall), .i_rx_req(rx_req), .i_tx_req(tx_req),
    .i_restart_req(rs_req), .o_rx_done(i_rx_done), .o_tx_done(i_tx_done),
    .o_restart(i_console_restart), .o_stack_ready(i_stack_ready));
  always #2 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    if (o_stack_push && i_stack_ready) words.push_back(o_stack_word);
    if (o_rsvd_operand) n_rsvd++;
    if (o_io_reset) n_iorst++;
  end
  task automatic wb(input logic w, input logic [5:0] ix,
      input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    i_wb_cyc <= 1'h1;
    i_wb_stb <= 1'h1;
    i_wb_we <= w;
    i_wb_adr <= {ix, 2'h0};
    i_wb_dat <= d;
    do begin @(posedge i_sys_clk); n++; end while (!o_wb_ack && n < 20);
    if (!o_wb_ack) begin
      n_fail++;
      $display("unexpected at %0t: bus acknowledge timed out", $time);
    end
    q = o_wb_dat;
    i_wb_cyc <= 1'h0;
    i_wb_stb <= 1'h0;
    @(posedge i_sys_clk);
  endtask
  task automatic halt_case(input hme_events_s ev, input logic [7:0] c);
    i_evt <= ev;
    @(posedge i_sys_clk);
    i_evt <= '0;
    @(posedge i_sys_clk);
    `CHK({o_halt, c != 8'h00 ? o_halt_code : 8'h00}, {c != 8'h00, c});
    rs_req <= 1'h1;
    @(posedge i_sys_clk);
    rs_req <= 1'h0;
    repeat (4) @(posedge i_sys_clk);
    `CHK(o_halt, 1'h0);
  endtask
  task automatic dev_case(input logic [5:0] ix, input logic [7:0] v);
    wb(1'h1, ix, 32'h40, rd);
    rx_req <= ix == `HME_IX_RX_STAT;
    tx_req <= ix == `HME_IX_TX_STAT;
    @(posedge i_sys_clk);
    rx_req <= 1'h0;
    tx_req <= 1'h0;
    repeat (3) @(posedge i_sys_clk);
    `CHK({o_dev_irq, o_dev_vector, o_dev_level}, {1'h1, v, `HME_VEC_LEVEL});
    wb(1'h1, ix, 32'h0, rd);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    tally_and_finish;
  end
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_arst_n <= 1'h1;
    @(posedge i_sys_clk);
    foreach (rows[i]) begin
      if (rows[i][64]) wb(1'h1, rows[i][70:65], 32'hFFFFFFFF, rd);
      wb(1'h0, rows[i][70:65], 32'h0, rd);
      `CHK(rd & rows[i][31:0], rows[i][63:32]);
    end
    `CHK(n_rsvd, 0);
    $display("register table done");
    foreach (hrows[i]) halt_case(hrows[i][48:8], hrows[i][7:0]);
    $display("halt table done");
    // ------------------------------------------------------------
    // machine check with a slow stack, double check, summary write
    // ------------------------------------------------------------
    i_mc_frame <= '{8'h81, expw[2], expw[3], expw[4], expw[5]};
    stall <= 1'h1;
    halt_case(41'h1, 8'h00);
    repeat (20) @(posedge i_sys_clk);
    `CHK(words.size(), 6);
    foreach (expw[i]) `CHK(words[i], expw[i]);
    halt_case(41'h1, `HME_HALT_DBL_MC);
    wb(1'h0, `HME_IX_HALT_CODE, 32'h0, rd);
    `CHK(rd, {24'h0, `HME_HALT_DBL_MC});
    wb(1'h1, `HME_IX_MC_SUMMARY, 32'h5A5A5A5A, rd);
    halt_case(41'h1, 8'h00);
    repeat (20) @(posedge i_sys_clk);
    `CHK(words.size(), 12);
    $display("machine check done");
    wb(1'h1, `HME_IX_BP_SILO, 32'h1, rd);
    wb(1'h1, `HME_IX_BP_TMO, 32'h1, rd);
    wb(1'h0, `HME_IX_BP_QCLR, 32'h0, rd);
    `CHK(n_rsvd, 3);
    wb(1'h0, `HME_IX_IRQ_STAT, 32'h0, rd);
    `CHK(rd[3], 1'h1);
    wb(1'h1, `HME_IX_IRQ_MASK, 32'h0, rd);
    irq_a = o_irq;
    wb(1'h1, `HME_IX_IRQ_MASK, 32'hF, rd);
    `CHK({irq_a, o_irq}, 2'h1);
    wb(1'h1, `HME_IX_IRQ_STAT, 32'hF, rd);
    wb(1'h0, `HME_IX_IRQ_STAT, 32'h0, rd);
    `CHK({rd[3:0], o_irq}, 5'h00);
    $display("faults and interrupts done");
    wb(1'h1, `HME_IX_IO_RESET, 32'h1, rd);
    `CHK(n_iorst, 1);
    wb(1'h1, `HME_IX_TX_DATA, 32'hC33C5AA5, rd);
    dev_case(`HME_IX_TX_STAT, `HME_VEC_TX);
    dev_case(`HME_IX_RX_STAT, `HME_VEC_RX);
    wb(1'h0, `HME_IX_RX_DATA, 32'h0, rd);
    `CHK(rd, 32'hC33C5AA5);
    $display("storage vectors done");
    i_evt <= 41'h10000000000;
    @(posedge i_sys_clk);
    i_evt <= '0;
    i_arst_n <= 1'h0;
    @(posedge i_sys_clk);
    `CHK({o_halt, o_halt_code, o_irq}, 10'h000);
    $display("reset done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
